// *** src/dpscs_top.sv ***
// Functional notes
// [RULE_01] schedule for write latency five, read latency eight, one-clock bus turnaround
// [RULE_02] five idle slots between a read and a following write
// [RULE_03] mixed read/write sets get idle slots; busy blocks new sets until drained
// [RULE_04] at least 1.5 memory clocks from port a bank access to port b same bank
// [RULE_05] port b delayed on same-bank collision; busy held until all commands done
// [RULE_06] never drive the data bus while the memory returns read data
// [RULE_07] lanes issued in order, lane zero first, lane three last
// [RULE_08] requests ignored until calibration done is high
// [RULE_09] user gives write address and data with the write opcode
// [RULE_10] user gives read address with the read opcode
// [RULE_11] read data returned on lane output with that lane's valid bit
// [RULE_12] port a command on rising command clock edge, port b on falling
// [RULE_13] address uses 21 bits in x36 mode, 22 bits in x18; rest reserved
// [RULE_14] address parity pin gives even parity over used address bits
// [RULE_15] memory pulls parity fault flag low until cleared by configuration
// [RULE_16] inversion pin covers used address bits and the parity bit together
// [RULE_17] opcode 00 idle, 01 reserved, 10 read, 11 write
// [RULE_18] user holds next set while ready low; sets offered then are dropped
// [RULE_19] memory takes a command only while that port's load pin is low
// [RULE_20] direction select low means write, high means read
// [RULE_21] same-direction lanes go back to back with no idle slots
// [RULE_22] four idle slots between a write and a following read
module dpscs_top #(
	parameter int DATA_W = 36,
	parameter int BANK_LSB = 0,
	parameter int BANK_W = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic calib_done,
	input wire logic port_a_cmd_en,
	input wire logic [3:0][1:0] port_a_lane_opcode,
	input wire logic [3:0][dpscs_pkg::ADDR_W-1:0] port_a_lane_location,
	input wire logic [3:0][DATA_W-1:0] port_a_lane_write_word,
	output logic port_a_ready,
	output logic [3:0][DATA_W-1:0] port_a_lane_read_word,
	output logic [3:0] port_a_read_valid,
	input wire logic port_b_cmd_en,
	input wire logic [3:0][1:0] port_b_lane_opcode,
	input wire logic [3:0][dpscs_pkg::ADDR_W-1:0] port_b_lane_location,
	input wire logic [3:0][DATA_W-1:0] port_b_lane_write_word,
	output logic port_b_ready,
	output logic [3:0][DATA_W-1:0] port_b_lane_read_word,
	output logic [3:0] port_b_read_valid,
	output logic mem_ck,
	output logic mem_ck_n,
	output logic [dpscs_pkg::ADDR_W-1:0] mem_addr,
	output logic address_parity_pin,
	output logic address_invert_pin,
	output logic port_a_load_low,
	output logic port_b_load_low,
	output logic port_a_dir_select,
	output logic port_b_dir_select,
	output logic [DATA_W-1:0] port_a_dq_out,
	output logic port_a_dq_oe,
	input wire logic [DATA_W-1:0] port_a_dq_in,
	output logic [DATA_W-1:0] port_b_dq_out,
	output logic port_b_dq_oe,
	input wire logic [DATA_W-1:0] port_b_dq_in,
	input wire logic parity_fault_flag_n
);
	localparam int L = dpscs_pkg::LANES;
	localparam int AW = dpscs_pkg::ADDR_W;
	localparam int WR_CYC = dpscs_pkg::WR_CYC;
	localparam int RD_CYC = dpscs_pkg::RD_CYC;

	// ---------------- register slave ----------------
	logic awready_q, wready_q, bvalid_q, aw_have_q, w_have_q;
	logic arready_q, rvalid_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q, rdata_q;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [1:0] ctrl_q;
	logic fault_q;
	logic wr_fire;

	assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= dpscs_pkg::RESP_OKAY;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_q) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
				awready_q <= 1'b0;
			end
			if (s_axi_wvalid && wready_q) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				wready_q <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				if (aw_addr_q == dpscs_pkg::REG_CTRL || aw_addr_q == dpscs_pkg::REG_FAULT) begin
					bresp_q <= dpscs_pkg::RESP_OKAY;
				end else begin
					bresp_q <= dpscs_pkg::RESP_DECERR;
				end
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= dpscs_pkg::CTRL_RESET;
		end else if (wr_fire && aw_addr_q == dpscs_pkg::REG_CTRL && w_strb_q[0]) begin
			ctrl_q <= w_data_q[1:0];
		end
	end

	// sticky record of the memory's parity fault; a new fault wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_q <= 1'b0;
		end else if (!parity_fault_flag_n) begin
			fault_q <= 1'b1; // RULE_15
		end else if (wr_fire && aw_addr_q == dpscs_pkg::REG_FAULT && w_strb_q[0]
			&& w_data_q[dpscs_pkg::FAULT_BIT]) begin
			fault_q <= 1'b0;
		end
	end

	logic ready_q [2];
	logic [31:0] status_w;

	always_comb begin
		status_w = 32'h0;
		status_w[dpscs_pkg::ST_CALIB_BIT] = calib_done;
		status_w[dpscs_pkg::ST_BUSY_A_BIT] = ~ready_q[0];
		status_w[dpscs_pkg::ST_BUSY_B_BIT] = ~ready_q[1];
		status_w[dpscs_pkg::ST_PFLAG_BIT] = ~parity_fault_flag_n;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= dpscs_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_q <= dpscs_pkg::RESP_OKAY;
			if (s_axi_araddr == dpscs_pkg::REG_CTRL) begin
				rdata_q <= {30'h0, ctrl_q};
			end else if (s_axi_araddr == dpscs_pkg::REG_STATUS) begin
				rdata_q <= status_w;
			end else if (s_axi_araddr == dpscs_pkg::REG_FAULT) begin
				rdata_q <= {31'h0, fault_q};
			end else begin
				rdata_q <= 32'h0;
				rresp_q <= dpscs_pkg::RESP_DECERR;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// ---------------- scheduler ----------------
	logic ck_q;
	logic cmd_en [2];
	logic [3:0][1:0] opc [2];
	logic [3:0][AW-1:0] loc [2];
	logic [3:0][DATA_W-1:0] wwd [2];
	logic [DATA_W-1:0] dq_in [2];
	logic go [2];
	logic go_wr [2];
	logic [AW-1:0] go_addr [2];
	logic [BANK_W-1:0] a_bank_q;
	logic [1:0] a_age_q;
	logic [3:0][DATA_W-1:0] rword_q [2];
	logic [3:0] rvld_q [2];
	logic [DATA_W-1:0] dq_out_q [2];
	logic dq_oe_q [2];

	assign cmd_en[0] = port_a_cmd_en;
	assign cmd_en[1] = port_b_cmd_en;
	assign opc[0] = port_a_lane_opcode;
	assign opc[1] = port_b_lane_opcode;
	assign loc[0] = port_a_lane_location;
	assign loc[1] = port_b_lane_location;
	assign wwd[0] = port_a_lane_write_word;
	assign wwd[1] = port_b_lane_write_word;
	assign dq_in[0] = port_a_dq_in;
	assign dq_in[1] = port_b_dq_in;

	// ck_q low means the next cycle is the rising half: port a's slot
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ck_q <= 1'b0;
		end else begin
			ck_q <= ~ck_q; // RULE_12
		end
	end

	// age of port a's last access, in half memory clocks, for the bank gap check
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_bank_q <= '0;
			a_age_q <= 2'h3;
		end else if (go[0]) begin
			a_bank_q <= go_addr[0][BANK_LSB +: BANK_W];
			a_age_q <= 2'h0;
		end else if (a_age_q != 2'h3) begin
			a_age_q <= a_age_q + 2'h1;
		end
	end

	for (genvar p = 0; p < 2; p++) begin : g_port
		logic [L-1:0] pend_q;
		logic [3:0][1:0] pop_q;
		logic [3:0][AW-1:0] paddr_q;
		logic [3:0][DATA_W-1:0] pdata_q;
		logic last_v_q, last_wr_q;
		logic [2:0] idles_q;
		logic [1:0] first;
		logic [2:0] need;
		logic slot, coll, accept;
		logic [L-1:0] lane_v, remain;
		logic [WR_CYC-1:0] wv_q;
		logic [DATA_W-1:0] wd_q [WR_CYC];
		logic [RD_CYC:0] rv_q;
		logic [1:0] rl_q [RD_CYC+1];

		assign slot = (p == 0) ? ~ck_q : ck_q;
		assign accept = cmd_en[p] & ready_q[p] & calib_done; // RULE_08

		always_comb begin
			first = 2'h0;
			for (int l = L - 1; l >= 0; l--) begin
				if (pend_q[l]) begin
					first = 2'(l); // RULE_07
				end
			end
			lane_v = '0;
			for (int l = 0; l < L; l++) begin
				lane_v[l] = opc[p][l] == dpscs_pkg::OP_READ || opc[p][l] == dpscs_pkg::OP_WRITE; // RULE_17
			end
		end

		assign go_wr[p] = pop_q[first] == dpscs_pkg::OP_WRITE;
		assign go_addr[p] = paddr_q[first];

		// no idles between like directions; wait for the gap when the direction flips
		always_comb begin
			need = 3'h0; // RULE_21
			if (last_v_q && !last_wr_q && go_wr[p]) begin
				need = 3'(dpscs_pkg::RD_TO_WR_IDLES); // RULE_02 RULE_06 RULE_01
			end else if (last_v_q && last_wr_q && !go_wr[p]) begin
				need = 3'(dpscs_pkg::WR_TO_RD_IDLES); // RULE_22
			end
		end

		// port b waits while port a touched the same bank less than 1.5 clocks ago
		assign coll = (p == 1) && go_addr[p][BANK_LSB +: BANK_W] == a_bank_q
			&& 32'(a_age_q) + 1 < dpscs_pkg::COLL_HALVES; // RULE_04 RULE_05
		assign go[p] = slot & (|pend_q) & (idles_q >= need) & ~coll; // RULE_03
		assign remain = pend_q & ~(go[p] ? L'(1) << first : L'(0));

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pend_q <= '0;
				pop_q <= '0;
				paddr_q <= '0;
				pdata_q <= '0;
			end else if (accept) begin
				pend_q <= lane_v;
				pop_q <= opc[p];
				paddr_q <= loc[p];
				pdata_q <= wwd[p];
			end else begin
				pend_q <= remain;
			end
		end

		// busy stays up until every accepted lane has gone out
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ready_q[p] <= 1'b0;
			end else begin
				ready_q[p] <= calib_done && !(accept && |lane_v) && remain == '0; // RULE_03 RULE_05
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				last_v_q <= 1'b0;
				last_wr_q <= 1'b0;
				idles_q <= 3'h7;
			end else if (go[p]) begin
				last_v_q <= 1'b1;
				last_wr_q <= go_wr[p];
				idles_q <= 3'h0;
			end else if (slot && idles_q != 3'h7) begin
				idles_q <= idles_q + 3'h1;
			end
		end

		// write data leaves WR_CYC cycles after its command reaches the pins
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				wv_q <= '0;
				dq_oe_q[p] <= 1'b0;
				dq_out_q[p] <= '0;
				for (int i = 0; i < WR_CYC; i++) begin
					wd_q[i] <= '0;
				end
			end else begin
				wv_q <= {wv_q[WR_CYC-2:0], go[p] & go_wr[p]};
				wd_q[0] <= pdata_q[first];
				for (int i = 1; i < WR_CYC; i++) begin
					wd_q[i] <= wd_q[i-1];
				end
				dq_oe_q[p] <= wv_q[WR_CYC-1]; // RULE_06
				dq_out_q[p] <= wd_q[WR_CYC-1];
			end
		end

		// read data sampled RD_CYC cycles after the command reaches the pins
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				rv_q <= '0;
				rvld_q[p] <= '0;
				rword_q[p] <= '0;
				for (int i = 0; i <= RD_CYC; i++) begin
					rl_q[i] <= 2'h0;
				end
			end else begin
				rv_q <= {rv_q[RD_CYC-1:0], go[p] & ~go_wr[p]};
				rl_q[0] <= first;
				for (int i = 1; i <= RD_CYC; i++) begin
					rl_q[i] <= rl_q[i-1];
				end
				rvld_q[p] <= '0;
				if (rv_q[RD_CYC]) begin
					rvld_q[p][rl_q[RD_CYC]] <= 1'b1; // RULE_11
					rword_q[p][rl_q[RD_CYC]] <= dq_in[p];
				end
			end
		end
	end

	// ---------------- memory command pins ----------------
	logic ck_pin_q, ck_n_pin_q, ap_q, address_invert_pin_q;
	logic [AW-1:0] addr_q, used, enc;
	logic [1:0] load_low_q, dir_q;
	logic sp;

	assign sp = ck_q;
	assign used = ctrl_q[dpscs_pkg::CTRL_X18_BIT] ? dpscs_pkg::USED_MASK_X18
		: dpscs_pkg::USED_MASK_X36; // RULE_13
	assign enc = go_addr[sp] & used;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ck_pin_q <= 1'b0;
			ck_n_pin_q <= 1'b1;
			addr_q <= '0;
			ap_q <= 1'b0;
			address_invert_pin_q <= 1'b0;
			load_low_q <= 2'h3;
			dir_q <= 2'h3;
		end else begin
			ck_pin_q <= ~ck_q;
			ck_n_pin_q <= ck_q;
			load_low_q <= {~go[1], ~go[0]}; // RULE_19
			if (go[sp]) begin
				dir_q[sp] <= ~go_wr[sp]; // RULE_20
				// inversion flips the used bits and the parity bit as one group
				if (ctrl_q[dpscs_pkg::CTRL_INV_BIT]) begin
					addr_q <= enc ^ used; // RULE_16
					ap_q <= ~(^enc);
				end else begin
					addr_q <= enc;
					ap_q <= ^enc; // RULE_14
				end
				address_invert_pin_q <= ctrl_q[dpscs_pkg::CTRL_INV_BIT];
			end
		end
	end

	assign mem_ck = ck_pin_q;
	assign mem_ck_n = ck_n_pin_q;
	assign mem_addr = addr_q;
	assign address_parity_pin = ap_q;
	assign address_invert_pin = address_invert_pin_q;
	assign port_a_load_low = load_low_q[0];
	assign port_b_load_low = load_low_q[1];
	assign port_a_dir_select = dir_q[0];
	assign port_b_dir_select = dir_q[1];
	assign port_a_ready = ready_q[0];
	assign port_b_ready = ready_q[1];
	assign port_a_lane_read_word = rword_q[0];
	assign port_b_lane_read_word = rword_q[1];
	assign port_a_read_valid = rvld_q[0];
	assign port_b_read_valid = rvld_q[1];
	assign port_a_dq_out = dq_out_q[0];
	assign port_b_dq_out = dq_out_q[1];
	assign port_a_dq_oe = dq_oe_q[0];
	assign port_b_dq_oe = dq_oe_q[1];
endmodule : dpscs_top

// *** src/dpscs_pkg.sv ***
package dpscs_pkg;
	// memory timing, in memory clocks
	localparam int WR_LAT = 5;
	localparam int RD_LAT = 8;
	localparam int BUS_TURN = 1;
	// idle slots between opposite-direction commands on one port
	localparam int RD_TO_WR_IDLES = 5;
	localparam int WR_TO_RD_IDLES = 4;
	// one memory clock spans two aclk cycles: rising half is port a, falling half port b
	localparam int HALVES_PER_MCLK = 2;
	localparam int WR_CYC = WR_LAT * HALVES_PER_MCLK;
	localparam int RD_CYC = RD_LAT * HALVES_PER_MCLK;
	// least bank gap from a port a access to a port b access, in half memory clocks (1.5 clk)
	localparam int COLL_HALVES = 3;
	// address pins
	localparam int ADDR_W = 25;
	localparam int USED_W_X36 = 21;
	localparam int USED_W_X18 = 22;
	localparam logic [ADDR_W-1:0] USED_MASK_X36 = 25'h01fffff;
	localparam logic [ADDR_W-1:0] USED_MASK_X18 = 25'h03fffff;
	// lane opcodes
	localparam logic [1:0] OP_IDLE = 2'h0;
	localparam logic [1:0] OP_RSVD = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h3;
	localparam int LANES = 4;
	// register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FAULT = 8'h08;
	localparam int CTRL_X18_BIT = 0;
	localparam int CTRL_INV_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int ST_CALIB_BIT = 0;
	localparam int ST_BUSY_A_BIT = 1;
	localparam int ST_BUSY_B_BIT = 2;
	localparam int ST_PFLAG_BIT = 3;
	localparam int FAULT_BIT = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : dpscs_pkg

// *** sim/dpscs_chk.sv ***
module dpscs_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic calib_done,
	input wire logic port_a_ready,
	input wire logic mem_ck,
	input wire logic [24:0] mem_addr,
	input wire logic address_parity_pin,
	input wire logic address_invert_pin,
	input wire logic port_a_load_low,
	input wire logic port_b_load_low,
	input wire logic port_a_dir_select,
	input wire logic port_a_dq_oe,
	input wire logic [3:0] port_a_read_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic cmd_on;
	logic even_ok;
	assign cmd_on = !port_a_load_low || !port_b_load_low;
	// inverted x18 addresses flip an odd bit count, so only plain addresses are judged
	assign even_ok = !(^{mem_addr, address_parity_pin}) || address_invert_pin;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_rd_a; !port_a_load_low && port_a_dir_select; endsequence
	sequence s_wr_a; !port_a_load_low && !port_a_dir_select; endsequence
	sequence s_no_wr; port_a_load_low || port_a_dir_select; endsequence
	sequence s_no_rd; port_a_load_low || !port_a_dir_select; endsequence
	a_ready_calib: assert property (!calib_done |=> !port_a_ready)
		else $error("ready without calibration");
	a_port_a_edge: assert property (!port_a_load_low |-> mem_ck)
		else $error("port a off rising half");
	a_port_b_edge: assert property (!port_b_load_low |-> !mem_ck)
		else $error("port b off falling half");
	a_addr_parity: assert property (cmd_on |-> even_ok)
		else $error("odd address parity");
	a_addr_upper: assert property (cmd_on |-> mem_addr[24:22] == 3'h0)
		else $error("reserved address bits set");
	a_write_lat: assert property (s_wr_a |-> ##10 port_a_dq_oe)
		else $error("write data late");
	a_read_ret: assert property (s_rd_a |-> ##17 port_a_read_valid != 4'h0)
		else $error("read data missing");
	a_no_clash: assert property (s_rd_a |-> ##16 !port_a_dq_oe)
		else $error("drive during read return");
	a_rd_wr_gap: assert property (s_rd_a |=> s_no_wr[*8] ##1 s_no_wr[*3])
		else $error("write too soon after read");
	a_wr_rd_gap: assert property (s_wr_a |=> s_no_rd[*8] ##1 s_no_rd)
		else $error("read too soon after write");
endmodule : dpscs_chk

bind dpscs_top dpscs_chk u_chk (.aclk, .aresetn, .calib_done, .port_a_ready, .mem_ck, .mem_addr,
	.address_parity_pin, .address_invert_pin, .port_a_load_low, .port_b_load_low,
	.port_a_dir_select, .port_a_dq_oe, .port_a_read_valid);

// *** sim/dpscs_user.sv ***
module dpscs_user (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic go,
	input wire logic [7:0] ops,
	input wire logic [24:0] loc,
	input wire logic ready,
	output logic cmd_en,
	output logic [3:0][1:0] opcode,
	output logic [3:0][24:0] location,
	output logic [3:0][35:0] write_word
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_en <= 1'b0;
			opcode <= '0;
			location <= '0;
			write_word <= '0;
		end else if (go) begin
			cmd_en <= 1'b1;
			opcode <= ops;
			for (int i = 0; i < 4; i++) begin
				location[i] <= loc;
				write_word[i] <= {9'h0, loc, 2'(i)};
			end
		end else if (cmd_en && ready) begin
			// stale lines are scrambled so nothing leans on them after the take
			cmd_en <= 1'b0;
			opcode <= '0;
			location <= ~location;
			write_word <= ~write_word;
		end
	end
endmodule : dpscs_user

// *** sim/test_dual_port_sram_cmd_scheduler.sv ***
module test_dual_port_sram_cmd_scheduler;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] ops; int n; int span; logic [3:0] dirs;} dpscs_row_s;
	logic aclk = 1'b0, aresetn = 1'b0, calib_done = 1'b0, parity_fault_flag_n = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, ops_a = 8'h0, ops_b = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf, port_a_read_valid, dirs_a = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go_a = 1'b0, go_b = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic port_a_cmd_en, port_b_cmd_en, port_a_ready, port_b_ready, mem_ck, port_a_dq_oe;
	logic port_a_load_low, port_b_load_low, port_a_dir_select;
	logic address_parity_pin, address_invert_pin;
	logic [24:0] loc_a = 25'h0, loc_b = 25'h0, mem_addr;
	logic [3:0][1:0] port_a_lane_opcode, port_b_lane_opcode;
	logic [3:0][24:0] port_a_lane_location, port_b_lane_location;
	logic [3:0][35:0] port_a_lane_write_word, port_b_lane_write_word, port_a_lane_read_word;
	logic [35:0] port_a_dq_in = 36'h0, port_b_dq_in;
	logic [35:0] port_a_dq_out, wq;
	logic [24:0] ma;
	logic mp, mi;
	int fail_count = 0, num_checks = 0, cyc = 0, na = 0, nb = 0, fa = 0, la = 0, fb = 0;
	dpscs_row_s rows [5] = '{'{8'haa, 4, 6, 4'hf}, '{8'hbb, 4, 32, 4'h5},
		'{8'hee, 4, 34, 4'ha}, '{8'ha4, 2, 2, 4'h3}, '{8'hff, 4, 6, 4'h0}};

	dpscs_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .calib_done, .port_a_cmd_en, .port_a_lane_opcode, .port_a_lane_location,
		.port_a_lane_write_word, .port_a_ready, .port_a_lane_read_word, .port_a_read_valid,
		.port_b_cmd_en, .port_b_lane_opcode, .port_b_lane_location, .port_b_lane_write_word,
		.port_b_ready, .port_b_lane_read_word(), .port_b_read_valid(), .mem_ck, .mem_ck_n(),
		.mem_addr, .address_parity_pin, .address_invert_pin, .port_a_load_low, .port_b_load_low,
		.port_a_dir_select, .port_b_dir_select(), .port_a_dq_out, .port_a_dq_oe, .port_a_dq_in,
		.port_b_dq_out(), .port_b_dq_oe(), .port_b_dq_in, .parity_fault_flag_n);
	dpscs_user u_user_a (.aclk, .aresetn, .go(go_a), .ops(ops_a), .loc(loc_a),
		.ready(port_a_ready), .cmd_en(port_a_cmd_en), .opcode(port_a_lane_opcode),
		.location(port_a_lane_location), .write_word(port_a_lane_write_word));
	dpscs_user u_user_b (.aclk, .aresetn, .go(go_b), .ops(ops_b), .loc(loc_b),
		.ready(port_b_ready), .cmd_en(port_b_cmd_en), .opcode(port_b_lane_opcode),
		.location(port_b_lane_location), .write_word(port_b_lane_write_word));

	always #2 aclk = ~aclk;
	assign port_b_dq_in = ~port_a_dq_in;
	// a counting data line makes every sampled read word traceable to its cycle
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		port_a_dq_in <= port_a_dq_in + 36'h1;
	end

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic conclude();
		if (fail_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	always @(negedge aclk) begin
		if (!port_a_load_low) begin
			na++;
			dirs_a = {dirs_a[2:0], port_a_dir_select};
			ma = mem_addr;
			mp = address_parity_pin;
			mi = address_invert_pin;
			if (na == 1) fa = cyc;
			la = cyc;
		end
		if (!port_b_load_low) begin
			nb++;
			if (nb == 1) fb = cyc;
		end
		if (port_a_dq_oe) wq = port_a_dq_out;
		for (int i = 0; i < 4; i++) begin
			if (port_a_read_valid[i]) chk(port_a_lane_read_word[i], port_a_dq_in - 36'h1);
		end
	end

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	task automatic settle();
		@(posedge aclk);
		while (port_a_cmd_en || port_b_cmd_en || !port_a_ready || !port_b_ready)
			@(posedge aclk);
		repeat (20) @(posedge aclk);
	endtask : settle

	task automatic launch(input logic [7:0] oa, ob, input logic [24:0] xa, xb);
		// the set is taken just before a port a slot, so port a leads port b
		while (!mem_ck) @(posedge aclk);
		na = 0;
		nb = 0;
		dirs_a = 4'h0;
		ops_a <= oa;
		ops_b <= ob;
		loc_a <= xa;
		loc_b <= xb;
		go_a <= 1'b1;
		go_b <= |ob;
		@(posedge aclk);
		go_a <= 1'b0;
		go_b <= 1'b0;
		// before calibration the set is held, not taken, so there is nothing to drain
		if (calib_done)
			settle();
		else
			repeat (20) @(posedge aclk);
	endtask : launch

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({port_a_ready, port_a_load_low, port_b_load_low, port_a_dq_oe}, 36'h6);
		launch(8'h03, 8'h00, 25'h1fabcde, 25'h0);
		chk(na, 36'h0);
		calib_done <= 1'b1;
		settle();
		chk(na, 36'h1);
		for (int i = 0; i < 5; i++) begin
			launch(rows[i].ops, 8'h00, 25'h1fabcde, 25'h0);
			chk(na, rows[i].n);
			chk(la - fa, rows[i].span);
			chk(dirs_a, rows[i].dirs);
		end
		chk({ma, mp, mi}, {25'h01abcde, 2'h0});
		chk(wq, {9'h0, 25'h1fabcde, 2'h3});
		launch(8'h03, 8'h03, 25'h0, 25'h0);
		chk(fb - fa, 36'h3);
		launch(8'h03, 8'h03, 25'h0, 25'h1);
		chk(fb - fa, 36'h1);
		axi_rd(dpscs_pkg::REG_STATUS, d, r);
		chk(d[dpscs_pkg::ST_CALIB_BIT], 36'h1);
		axi_wr(dpscs_pkg::REG_CTRL, 32'h3, r);
		axi_rd(dpscs_pkg::REG_CTRL, d, r);
		chk({d, r}, {32'h3, dpscs_pkg::RESP_OKAY});
		launch(8'h03, 8'h00, 25'h1fabcde, 25'h0);
		chk({ma, mp, mi}, {25'h0054321, 2'h1});
		axi_wr(8'h40, 32'h1, r);
		chk(r, dpscs_pkg::RESP_DECERR);
		axi_rd(8'h40, d, r);
		chk({d, r}, {32'h0, dpscs_pkg::RESP_DECERR});
		parity_fault_flag_n <= 1'b0;
		repeat (2) @(posedge aclk);
		parity_fault_flag_n <= 1'b1;
		axi_rd(dpscs_pkg::REG_FAULT, d, r);
		chk(d[0], 36'h1);
		axi_wr(dpscs_pkg::REG_FAULT, 32'h1, r);
		axi_rd(dpscs_pkg::REG_FAULT, d, r);
		chk(d[0], 36'h0);
		conclude();
	end

	initial begin
		repeat (5000) @(posedge aclk);
		fail_count++;
		conclude();
	end
endmodule : test_dual_port_sram_cmd_scheduler
